// >>> hdl/dhp_pkg.sv
// Package with constants and the command-class decoder of the host I/O port
// What this block does
// [RULE1] Mask instruction with bit 7 set blocks interrupt requests until cleared
// [RULE2] Master reset clears all state, selects unit zero, command becomes read
// [RULE3] Four skip tests: busy clear, busy set, done clear, done set
// [RULE4] Command write bit 0 clears transfer done, bits 1-4 clear seek attention
// [RULE5] Bits 5-8 pick the command; transfers need start, others pulse or none
// [RULE6] Bits 9-10 pick drive unit 0 to 3 for the command
// [RULE7] Command write reserves the selected drive if not yet reserved
// [RULE8] Small-disk emulation ignores bit 9, so only two units selectable
// [RULE9] Bits 11-15 are reserved; no function attached to them
// [RULE10] Memory-address write loads the start address of next transfer
// [RULE11] For a seek the drive-address word low bits give the cylinder
// [RULE12] For transfers the word gives surface, sector and two's-complement count; read buffers ignores the word
// [RULE13] Host issues exactly one drive-address write per transfer command; the bench issues three after one read, each overwriting the last
// [RULE14] Sector address taken from a five-bit field only, sectors 0 to 31
// [RULE15] Start sets busy, clears done, interrupt, faults, begins transfer
// [RULE16] Pulse sets control full and begins the held non-transfer command; the two alternate-mode commands ignore it
// [RULE17] Clear resets busy, done, flags, interrupt, faults and aborts transfer
package dhp_pkg;

  // Host bit n of the accumulator is word bit 15-n
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned MASK_BIT     = 8;   // host bit 7
  localparam int unsigned XDONE_BIT    = 15;  // host bit 0
  localparam int unsigned ATTN_HI      = 14;  // host bits 1-4
  localparam int unsigned ATTN_LO      = 11;
  localparam int unsigned CMD_HI       = 10;  // host bits 5-8
  localparam int unsigned CMD_LO       = 7;
  localparam int unsigned UNIT_HI      = 6;   // host bits 9-10
  localparam int unsigned UNIT_LO      = 5;
  localparam int unsigned SURF_HI      = 14;  // host bits 1-5
  localparam int unsigned SURF_LO      = 10;
  localparam int unsigned SECT_HI      = 9;   // host bits 6-10
  localparam int unsigned SECT_LO      = 5;
  localparam int unsigned CNT_HI       = 4;   // host bits 11-15
  localparam int unsigned CNT_LO       = 0;
  localparam int unsigned CYL_W        = 10;
  localparam int unsigned NUM_UNITS    = 4;

  // Skip test selects
  localparam logic [1:0] SKIP_NOT_BUSY = 2'h0;
  localparam logic [1:0] SKIP_BUSY     = 2'h1;
  localparam logic [1:0] SKIP_NOT_DONE = 2'h2;
  localparam logic [1:0] SKIP_DONE     = 2'h3;

  // I/O function codes carried with an instruction
  localparam logic [1:0] FN_NONE       = 2'h0;
  localparam logic [1:0] FN_START      = 2'h1;
  localparam logic [1:0] FN_CLEAR      = 2'h2;
  localparam logic [1:0] FN_PULSE      = 2'h3;

  localparam logic [1:0] UNIT_RST      = 2'h0;

  typedef enum logic [3:0] {
    CMD_READ      = 4'h0,
    CMD_RECAL     = 4'h1,
    CMD_SEEK      = 4'h2,
    CMD_STOP      = 4'h3,
    CMD_OFS_FWD   = 4'h4,
    CMD_OFS_REV   = 4'h5,
    CMD_WR_DIS    = 4'h6,
    CMD_RELEASE   = 4'h7,
    CMD_TRESPASS  = 4'h8,
    CMD_ALT1      = 4'h9,
    CMD_ALT2      = 4'ha,
    CMD_EXAM_MEM  = 4'hb,
    CMD_VERIFY    = 4'hc,
    CMD_RD_BUF    = 4'hd,
    CMD_WRITE     = 4'he,
    CMD_FORMAT    = 4'hf
  } dhp_cmd_e;

endpackage

`timescale 1ns/1ps
// Classifies a command code by the function that launches it
module dhp_cmd_class (
  // Command code
  input  wire logic [3:0] cmd_i,
  // Classes
  output logic            is_xfer_o,
  output logic            is_pulse_o,
  output logic            is_alt_o,
  output logic            uses_addr_o
);

  always_comb begin
    // [RULE5] Function classes
    case (cmd_i)
      dhp_pkg::CMD_READ, dhp_pkg::CMD_VERIFY, dhp_pkg::CMD_RD_BUF,
      dhp_pkg::CMD_WRITE, dhp_pkg::CMD_FORMAT: begin
        is_xfer_o  = 1'b1;
        is_pulse_o = 1'b0;
        is_alt_o   = 1'b0;
      end
      dhp_pkg::CMD_ALT1, dhp_pkg::CMD_ALT2: begin
        is_xfer_o  = 1'b0;
        is_pulse_o = 1'b0;
        is_alt_o   = 1'b1;
      end
      default: begin
        is_xfer_o  = 1'b0;
        is_pulse_o = 1'b1;
        is_alt_o   = 1'b0;
      end
    endcase
    // Read buffers moves no disk sectors, so no drive address applies
    uses_addr_o = (cmd_i == dhp_pkg::CMD_READ)  ||
                  (cmd_i == dhp_pkg::CMD_WRITE) ||
                  (cmd_i == dhp_pkg::CMD_FORMAT) ||
                  (cmd_i == dhp_pkg::CMD_VERIFY);
  end

endmodule

// >>> hdl/dhp_port.sv
// Host-facing programmed I/O port of a four-drive disk controller
`timescale 1ns/1ps
module dhp_port #(
  parameter int unsigned CYL_W = dhp_pkg::CYL_W
) (
  // Clock, reset, enable
  input  wire logic                 ref_clk_i,
  input  wire logic                 srst_i,
  input  wire logic                 clk_en_i,
  // Host instruction strobes, one cycle each
  input  wire logic                 mask_out_instr_i,
  input  wire logic                 master_reset_instr_i,
  input  wire logic                 command_word_write_i,
  input  wire logic                 mem_addr_write_i,
  input  wire logic                 drive_addr_write_i,
  input  wire logic [1:0]           io_func_i,
  input  wire logic [15:0]          ac_data_i,
  // Skip test
  input  wire logic                 skip_req_i,
  input  wire logic [1:0]           skip_sel_i,
  output logic                      skip_o,
  // Configuration
  input  wire logic                 small_disk_emulation_i,
  // Completion events from the command engine
  input  wire logic                 xfer_complete_i,
  input  wire logic                 ctrl_complete_i,
  input  wire logic [3:0]           seek_complete_i,
  // Status
  output logic                      busy_o,
  output logic                      done_o,
  output logic                      ctrl_full_o,
  output logic                      transfer_done_flag_o,
  output logic [3:0]                seek_attn_o,
  output logic                      int_mask_o,
  output logic                      int_req_o,
  // Command state toward the engine
  output logic [3:0]                cmd_o,
  output logic [1:0]                unit_o,
  output logic [3:0]                reserved_o,
  output logic [1:0]                alt_mode_o,
  output logic [15:0]               mem_addr_o,
  output logic [CYL_W-1:0]          cylinder_o,
  output logic [4:0]                surface_o,
  output logic [4:0]                sector_o,
  output logic [4:0]                count_o,
  output logic                      start_xfer_o,
  output logic                      start_ctrl_o,
  output logic                      abort_o,
  output logic                      fault_clr_o
);

  typedef struct packed {
    logic             skip;
    logic             busy;
    logic             done;
    logic             ctrl_full;
    logic             xdone;
    logic [3:0]       attn;
    logic             mask;
    logic             irq;
    logic [3:0]       cmd;
    logic [1:0]       unit;
    logic [3:0]       rsv;
    logic [1:0]       alt;
    logic [15:0]      maddr;
    logic [CYL_W-1:0] cyl;
    logic [4:0]       surf;
    logic [4:0]       sect;
    logic [4:0]       cnt;
    logic             st_x;
    logic             st_c;
    logic             abrt;
    logic             fclr;
  } dhp_state_s;

  dhp_state_s st_q;
  dhp_state_s st_d;

  logic       is_xfer;
  logic       is_pulse;
  logic       is_alt;
  logic       uses_addr;
  logic [3:0] wr_cmd;
  logic [1:0] wr_unit;

  // [RULE9] Reserved bits 11-15 reach no command-write logic
  assign wr_cmd  = ac_data_i[dhp_pkg::CMD_HI:dhp_pkg::CMD_LO];
  // [RULE8] Bit 9 dropped under emulation
  assign wr_unit = {ac_data_i[dhp_pkg::UNIT_HI] & ~small_disk_emulation_i,
                    ac_data_i[dhp_pkg::UNIT_LO]};

  // Classes of the held command, which start and pulse act on
  dhp_cmd_class u_class (
    .cmd_i       (st_q.cmd),
    .is_xfer_o   (is_xfer),
    .is_pulse_o  (is_pulse),
    .is_alt_o    (is_alt),
    .uses_addr_o (uses_addr)
  );

  always_comb begin
    st_d      = st_q;
    st_d.skip = 1'b0;
    st_d.st_x = 1'b0;
    st_d.st_c = 1'b0;
    st_d.abrt = 1'b0;
    st_d.fclr = 1'b0;

    // [RULE3] Skip tests
    if (skip_req_i) begin
      case (skip_sel_i)
        dhp_pkg::SKIP_NOT_BUSY: st_d.skip = ~st_q.busy;
        dhp_pkg::SKIP_BUSY:     st_d.skip = st_q.busy;
        dhp_pkg::SKIP_NOT_DONE: st_d.skip = ~st_q.done;
        default:                st_d.skip = st_q.done;
      endcase
    end

    // [RULE1] Interrupt mask
    if (mask_out_instr_i) begin
      st_d.mask = ac_data_i[dhp_pkg::MASK_BIT];
    end

    // A release frees its unit; a same-cycle command write selecting that unit re-reserves it
    if (st_q.cmd == dhp_pkg::CMD_RELEASE && st_q.st_c) begin
      st_d.rsv[st_q.unit] = 1'b0;
    end

    if (command_word_write_i) begin
      // [RULE4] Flag clears; host bit 1 is unit 0, so the order flips
      if (ac_data_i[dhp_pkg::XDONE_BIT]) begin
        st_d.xdone = 1'b0;
      end
      for (int u = 0; u < dhp_pkg::NUM_UNITS; u++) begin
        if (ac_data_i[dhp_pkg::ATTN_HI - u]) begin
          st_d.attn[u] = 1'b0;
        end
      end
      // [RULE5] Command capture
      st_d.cmd  = wr_cmd;
      // [RULE6] Drive selection
      st_d.unit = wr_unit;
      // [RULE7] Reserve drive
      st_d.rsv[wr_unit] = 1'b1;
      st_d.alt = 2'h0;
      if (wr_cmd == dhp_pkg::CMD_ALT1) begin
        st_d.alt = 2'h1;
      end else if (wr_cmd == dhp_pkg::CMD_ALT2) begin
        st_d.alt = 2'h2;
      end
    end

    // [RULE10] Start address load
    if (mem_addr_write_i) begin
      st_d.maddr = ac_data_i;
    end

    if (drive_addr_write_i) begin
      // [RULE11] Cylinder for seek
      if (st_q.cmd == dhp_pkg::CMD_SEEK) begin
        st_d.cyl = ac_data_i[CYL_W-1:0];
      end else if (uses_addr) begin
        // [RULE12] Surface, sector, count
        st_d.surf = ac_data_i[dhp_pkg::SURF_HI:dhp_pkg::SURF_LO];
        // [RULE14] Five-bit sector
        st_d.sect = ac_data_i[dhp_pkg::SECT_HI:dhp_pkg::SECT_LO];
        st_d.cnt  = ac_data_i[dhp_pkg::CNT_HI:dhp_pkg::CNT_LO];
      end
    end

    // Completion first, so a same-cycle pulse keeps control full set
    if (ctrl_complete_i) begin
      st_d.ctrl_full = 1'b0;
    end

    case (io_func_i)
      dhp_pkg::FN_START: begin
        // [RULE15] Start function
        if (is_xfer) begin
          st_d.busy = 1'b1;
          st_d.done = 1'b0;
          st_d.fclr = 1'b1;
          st_d.st_x = 1'b1;
        end
      end
      dhp_pkg::FN_PULSE: begin
        // [RULE16] Pulse function
        if (is_pulse) begin
          st_d.ctrl_full = 1'b1;
          st_d.st_c      = 1'b1;
        end
      end
      dhp_pkg::FN_CLEAR: begin
        // [RULE17] Clear function
        st_d.busy  = 1'b0;
        st_d.done  = 1'b0;
        st_d.abrt  = 1'b1;
        st_d.fclr  = 1'b1;
        st_d.xdone = 1'b0;
        st_d.attn  = 4'h0;
      end
      default: begin
      end
    endcase

    // Engine events come last so a set beats a same-cycle clear
    if (xfer_complete_i) begin
      st_d.busy  = 1'b0;
      st_d.done  = 1'b1;
      st_d.xdone = 1'b1;
    end
    if (|seek_complete_i) begin
      st_d.attn = st_d.attn | seek_complete_i;
      st_d.done = 1'b1;
    end
    // [RULE1] Request only while unmasked; cleared with done
    st_d.irq = st_d.done & ~st_d.mask;

    // [RULE2] Master reset
    if (master_reset_instr_i) begin
      st_d      = '0;
      st_d.unit = dhp_pkg::UNIT_RST;
      st_d.cmd  = dhp_pkg::CMD_READ;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_q <= '0;
    end else if (clk_en_i) begin
      st_q <= st_d;
    end
  end

  assign skip_o               = st_q.skip;
  assign busy_o               = st_q.busy;
  assign done_o               = st_q.done;
  assign ctrl_full_o          = st_q.ctrl_full;
  assign transfer_done_flag_o = st_q.xdone;
  assign seek_attn_o          = st_q.attn;
  assign int_mask_o           = st_q.mask;
  assign int_req_o            = st_q.irq;
  assign cmd_o                = st_q.cmd;
  assign unit_o               = st_q.unit;
  assign reserved_o           = st_q.rsv;
  assign alt_mode_o           = st_q.alt;
  assign mem_addr_o           = st_q.maddr;
  assign cylinder_o           = st_q.cyl;
  assign surface_o            = st_q.surf;
  assign sector_o             = st_q.sect;
  assign count_o              = st_q.cnt;
  assign start_xfer_o         = st_q.st_x;
  assign start_ctrl_o         = st_q.st_c;
  assign abort_o              = st_q.abrt;
  assign fault_clr_o          = st_q.fclr;

  // Checks
  property p_mask_blocks;
    @(posedge ref_clk_i) disable iff (srst_i)
      int_mask_o |-> !int_req_o;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) // [RULE1]
    else $error("interrupt request while masked");

  property p_mreset;
    @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && master_reset_instr_i |=>
        cmd_o == 4'h0 && unit_o == 2'h0 && !busy_o && !done_o;
  endproperty
  a_mreset: assert property (p_mreset) // [RULE2]
    else $error("master reset left state behind");

  property p_skip_busy;
    @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && skip_req_i && skip_sel_i == 2'h1 &&
      !master_reset_instr_i |=> skip_o == $past(busy_o);
  endproperty
  a_skip_busy: assert property (p_skip_busy) // [RULE3]
    else $error("skip on busy wrong");

  property p_skip_ndone;
    @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && skip_req_i && skip_sel_i == 2'h2 &&
      !master_reset_instr_i |=> skip_o != $past(done_o);
  endproperty
  a_skip_ndone: assert property (p_skip_ndone) // [RULE3]
    else $error("skip on done clear wrong");

  property p_attn_clr;
    @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && command_word_write_i && !master_reset_instr_i &&
      ac_data_i[14] && !seek_complete_i[0] |=> !seek_attn_o[0];
  endproperty
  a_attn_clr: assert property (p_attn_clr) // [RULE4]
    else $error("unit 0 attention not cleared");

  property p_unit_emul;
    @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && command_word_write_i && small_disk_emulation_i &&
      !master_reset_instr_i |=> !unit_o[1];
  endproperty
  a_unit_emul: assert property (p_unit_emul) // [RULE8]
    else $error("upper unit selected under emulation");

  property p_reserve;
    @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && command_word_write_i && !master_reset_instr_i |=>
        reserved_o[unit_o];
  endproperty
  a_reserve: assert property (p_reserve) // [RULE7]
    else $error("selected drive not reserved");

  property p_start;
    @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && io_func_i == 2'h1 && !master_reset_instr_i &&
      (cmd_o == 4'h0 || cmd_o >= 4'hc) && !xfer_complete_i &&
      !(|seek_complete_i) |=>
        start_xfer_o && busy_o && !done_o && fault_clr_o;
  endproperty
  a_start: assert property (p_start) // [RULE15]
    else $error("start pulse without busy");

  property p_pulse;
    @(posedge ref_clk_i) disable iff (srst_i)
      start_ctrl_o |-> ctrl_full_o;
  endproperty
  a_pulse: assert property (p_pulse) // [RULE16]
    else $error("control full not set by pulse");

  property p_clear;
    @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && io_func_i == 2'h2 && !master_reset_instr_i &&
      !xfer_complete_i && !(|seek_complete_i) |=>
        !busy_o && !done_o && abort_o && !int_req_o;
  endproperty
  a_clear: assert property (p_clear) // [RULE17]
    else $error("clear function incomplete");

endmodule

// >>> sim/dhp_host_model.sv
// Host processor model issuing programmed I/O instructions to the port
`timescale 1ns/1ps
module dhp_host_model (
  // Clock
  input  wire logic        ref_clk_i,
  // Instruction strobes and accumulator
  output logic             mask_out_instr_o,
  output logic             master_reset_instr_o,
  output logic             command_word_write_o,
  output logic             mem_addr_write_o,
  output logic             drive_addr_write_o,
  output logic [1:0]       io_func_o,
  output logic [15:0]      ac_data_o,
  // Skip test
  output logic             skip_req_o,
  output logic [1:0]       skip_sel_o
);
  initial begin
    {mask_out_instr_o, master_reset_instr_o, command_word_write_o} = 3'h0;
    {mem_addr_write_o, drive_addr_write_o, skip_req_o} = 3'h0;
    io_func_o = 2'h0;
    skip_sel_o = 2'h0;
    ac_data_o = 16'h0;
  end

  // Every call drives each pin once and holds it over one edge, so calls
  // back to back never assign a pin twice in one time step
  task automatic drive(input logic [2:0] kind, input logic [1:0] fn,
                       input logic [15:0] d, input logic sk,
                       input logic [1:0] sel);
    mask_out_instr_o = (kind == 3'h1);
    master_reset_instr_o = (kind == 3'h2);
    command_word_write_o = (kind == 3'h3);
    mem_addr_write_o = (kind == 3'h4);
    drive_addr_write_o = (kind == 3'h5);
    io_func_o = fn;
    ac_data_o = d;
    skip_req_o = sk;
    skip_sel_o = sel;
    @(posedge ref_clk_i);
    #1;
  endtask

  // Kind: 0 none, 1 mask, 2 reset, 3 command, 4 memory, 5 drive
  task automatic instr(input logic [2:0] kind, input logic [1:0] fn,
                       input logic [15:0] d);
    drive(kind, fn, d, 1'b0, ~skip_sel_o);
  endtask

  // Released accumulator must not keep showing the last word
  task automatic skip(input logic [1:0] sel);
    drive(3'h0, 2'h0, ~ac_data_o, 1'b1, sel);
  endtask

  task automatic idle();
    drive(3'h0, 2'h0, ~ac_data_o, 1'b0, ~skip_sel_o);
  endtask
endmodule

// >>> sim/disk_ctrl_host_io_port_bench.sv
// Self-checking bench for the host I/O port
`timescale 1ns/1ps
module disk_ctrl_host_io_port_bench;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic small_disk_emulation_i = 1'b0;
  logic xfer_complete_i = 1'b0;
  logic ctrl_complete_i = 1'b0;
  logic [3:0] seek_complete_i = 4'h0;
  logic mask_out_instr_i, master_reset_instr_i, command_word_write_i;
  logic mem_addr_write_i, drive_addr_write_i, skip_req_i, skip_o;
  logic [1:0] io_func_i, skip_sel_i, unit_o, alt_mode_o;
  logic [15:0] ac_data_i, mem_addr_o;
  logic busy_o, done_o, ctrl_full_o, transfer_done_flag_o, int_mask_o;
  logic int_req_o, start_xfer_o, start_ctrl_o, abort_o, fault_clr_o;
  logic [3:0] seek_attn_o, cmd_o, reserved_o;
  logic [9:0] cylinder_o;
  logic [4:0] surface_o, sector_o, count_o;
  int failures = 0;
  int n_tests = 0;
  int seed = 32'hdc45;

  always #5 ref_clk_i = ~ref_clk_i;

  dhp_port dhp_port_inst (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .clk_en_i(clk_en_i),
    .mask_out_instr_i(mask_out_instr_i),
    .master_reset_instr_i(master_reset_instr_i),
    .command_word_write_i(command_word_write_i),
    .mem_addr_write_i(mem_addr_write_i),
    .drive_addr_write_i(drive_addr_write_i), .io_func_i(io_func_i),
    .ac_data_i(ac_data_i), .skip_req_i(skip_req_i),
    .skip_sel_i(skip_sel_i), .skip_o(skip_o),
    .small_disk_emulation_i(small_disk_emulation_i),
    .xfer_complete_i(xfer_complete_i), .ctrl_complete_i(ctrl_complete_i),
    .seek_complete_i(seek_complete_i), .busy_o(busy_o), .done_o(done_o),
    .ctrl_full_o(ctrl_full_o), .transfer_done_flag_o(transfer_done_flag_o),
    .seek_attn_o(seek_attn_o), .int_mask_o(int_mask_o),
    .int_req_o(int_req_o), .cmd_o(cmd_o), .unit_o(unit_o),
    .reserved_o(reserved_o), .alt_mode_o(alt_mode_o),
    .mem_addr_o(mem_addr_o), .cylinder_o(cylinder_o),
    .surface_o(surface_o), .sector_o(sector_o), .count_o(count_o),
    .start_xfer_o(start_xfer_o), .start_ctrl_o(start_ctrl_o),
    .abort_o(abort_o), .fault_clr_o(fault_clr_o));

  dhp_host_model dhp_host_model_inst (
    .ref_clk_i(ref_clk_i), .mask_out_instr_o(mask_out_instr_i),
    .master_reset_instr_o(master_reset_instr_i),
    .command_word_write_o(command_word_write_i),
    .mem_addr_write_o(mem_addr_write_i),
    .drive_addr_write_o(drive_addr_write_i), .io_func_o(io_func_i),
    .ac_data_o(ac_data_i), .skip_req_o(skip_req_i),
    .skip_sel_o(skip_sel_i));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    dhp_host_model_inst.idle();
  endtask

  task automatic give_verdict();
    $display("tests=%0d failures=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  function automatic logic xfer_f(input logic [3:0] c);
    return c == 4'h0 || c >= 4'hc;
  endfunction

  function automatic logic alt_f(input logic [3:0] c);
    return c == 4'h9 || c == 4'ha;
  endfunction

  function automatic logic skip_f(input logic [1:0] s, input logic b,
                                  input logic d);
    case (s)
      dhp_pkg::SKIP_NOT_BUSY: return !b;
      dhp_pkg::SKIP_BUSY:     return b;
      dhp_pkg::SKIP_NOT_DONE: return !d;
      default:                return d;
    endcase
  endfunction

  // Generous bound; the sequence needs about 80 cycles
  initial begin
    #100000;
    failures++;
    give_verdict();
  end

  initial begin
    logic [31:0] r;
    logic [3:0]  cc;
    logic [9:0]  cyl;
    repeat (2) @(posedge ref_clk_i);
    #1;
    srst_i = 1'b0;
    chk(cmd_o, 16'h0);
    chk(busy_o | done_o | int_req_o, 1'b0);
    for (int c = 0; c < 16; c++) begin
      r = $random(seed);
      cc = 4'(c);
      dhp_host_model_inst.instr(3'h3, 2'h0, {5'h0, cc, r[1:0], r[10:6]});
      chk(cmd_o, cc);
      chk(unit_o, r[1:0]);
      chk(reserved_o[r[1:0]], 1'b1);
      chk(alt_mode_o, alt_f(cc) ? cc[1:0] : 2'h0);
      dhp_host_model_inst.instr(3'h0, xfer_f(cc) ? dhp_pkg::FN_START :
                                dhp_pkg::FN_PULSE, 16'h0);
      chk(start_xfer_o, xfer_f(cc));
      chk({busy_o, done_o, fault_clr_o}, {xfer_f(cc), 1'b0, xfer_f(cc)});
      chk(start_ctrl_o, !xfer_f(cc) && !alt_f(cc));
      chk(ctrl_full_o, !xfer_f(cc) && !alt_f(cc));
      ctrl_complete_i = 1'b1;
      dhp_host_model_inst.instr(3'h0, dhp_pkg::FN_CLEAR, 16'h0);
      ctrl_complete_i = 1'b0;
      chk({busy_o, ctrl_full_o, int_req_o, abort_o}, 4'h1);
    end
    dhp_host_model_inst.instr(3'h3, 2'h0, 16'h0);
    dhp_host_model_inst.instr(3'h0, dhp_pkg::FN_START, 16'h0);
    for (int s = 0; s < 4; s++) begin
      dhp_host_model_inst.skip(2'(s));
      chk(skip_o, skip_f(2'(s), 1'b1, 1'b0));
    end
    xfer_complete_i = 1'b1;
    tick();
    xfer_complete_i = 1'b0;
    for (int s = 0; s < 4; s++) begin
      dhp_host_model_inst.skip(2'(s));
      chk(skip_o, skip_f(2'(s), 1'b0, 1'b1));
    end
    chk({transfer_done_flag_o, int_req_o}, 2'h3);
    dhp_host_model_inst.instr(3'h1, 2'h0, 16'h0100);
    chk({int_mask_o, int_req_o}, 2'h2);
    dhp_host_model_inst.instr(3'h1, 2'h0, 16'hfeff);
    chk({int_mask_o, int_req_o}, 2'h1);
    dhp_host_model_inst.instr(3'h0, dhp_pkg::FN_CLEAR, 16'h0);
    chk({done_o, int_req_o, transfer_done_flag_o}, 3'h0);
    dhp_host_model_inst.instr(3'h1, 2'h0, 16'h0100);
    seek_complete_i = 4'hf;
    xfer_complete_i = 1'b1;
    tick();
    seek_complete_i = 4'h0;
    xfer_complete_i = 1'b0;
    chk({seek_attn_o, int_req_o}, 5'h1e);
    r = $random(seed);
    dhp_host_model_inst.instr(3'h3, 2'h0, {1'b1, r[3:0], 11'h0});
    chk(transfer_done_flag_o, 1'b0);
    chk(seek_attn_o, 4'(~{r[0], r[1], r[2], r[3]}));
    small_disk_emulation_i = 1'b1;
    dhp_host_model_inst.instr(3'h3, 2'h0, {5'h0, 4'h2, 2'h3, 5'h1f});
    small_disk_emulation_i = 1'b0;
    chk(unit_o, 2'h1);
    repeat (3) begin
      r = $random(seed);
      dhp_host_model_inst.instr(3'h5, 2'h0, r[15:0]);
      cyl = r[9:0];
      chk(cylinder_o, cyl);
    end
    dhp_host_model_inst.instr(3'h3, 2'h0, {5'h0, 4'h0, 2'h3, 5'h0});
    repeat (3) begin
      r = $random(seed);
      dhp_host_model_inst.instr(3'h5, 2'h0, r[15:0]);
      chk({surface_o, count_o}, {r[14:10], r[4:0]});
      chk(sector_o, r[9:5]);
      chk(cylinder_o, cyl);
      dhp_host_model_inst.instr(3'h4, 2'h0, r[31:16]);
      chk(mem_addr_o, r[31:16]);
    end
    clk_en_i = 1'b0;
    dhp_host_model_inst.instr(3'h3, 2'h0, {5'h0, 4'h2, 2'h1, 5'h0});
    clk_en_i = 1'b1;
    chk({cmd_o, unit_o}, {4'h0, 2'h3});
    dhp_host_model_inst.instr(3'h2, 2'h0, 16'h0);
    tick();
    chk({cmd_o, unit_o, int_mask_o, done_o}, 8'h0);
    give_verdict();
  end
endmodule
